// [hw/irq_flags_pkg.sv]
// package for the peripheral interrupt request flag block
// assumes a 32-bit AXI4-Lite register bus, byte addressing
package irq_flags_pkg;
  // register byte offsets
  localparam logic [11:0] FLAGS1_OFFSET = 12'h000; // flag register 1
  localparam logic [11:0] FLAGS7_OFFSET = 12'h004; // flag register 7
  localparam logic [11:0] EVSTAT_OFFSET = 12'h008; // sticky event status
  localparam logic [11:0] EVMASK_OFFSET = 12'h00C; // event mask
  // flag register 1 field positions
  localparam int OSC_FAILSAFE_BIT = 7;
  localparam int CLOCK_SWITCH_BIT = 6;
  localparam int CONV_THRESH_BIT = 1;
  localparam int CONV_DONE_BIT = 0;
  // flag register 7 field positions
  localparam int SCANNER_BIT = 7;
  localparam int CHECKSUM_BIT = 6;
  localparam int MEMOP_BIT = 5;
  localparam int ROLLOVER_BIT = 4;
  localparam int WAVE3_BIT = 2;
  localparam int WAVE2_BIT = 1;
  localparam int WAVE1_BIT = 0;
  // implemented bit masks
  localparam logic [7:0] FLAGS1_IMPL = 8'hC3;
  localparam logic [7:0] FLAGS7_IMPL = 8'hF7;
  // reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] EVENT_RESET = 16'h0000;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irq_flags_pkg

// [hw/flag_cell.sv]
// one hardware-set, software-cleared flag bit
// assumes set and clear come from logic on sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module flag_cell
(
  input wire logic sys_clk_i, // system clock
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic set_i, // hardware event, one cycle
  input wire logic clr_i, // software writes zero
  output logic flag_o // flag state
);
  logic flag_reg; // stored flag
  logic flag_next; // next flag

  // set wins over clear; only software clears
  always_comb
  begin
    flag_next = flag_reg;
    if (clr_i)
    begin
      flag_next = 1'b0; // software clear
    end
    if (set_i)
    begin
      flag_next = 1'b1; // set regardless of enables
    end
  end

  // register with synchronous reset to zero
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      flag_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
endmodule : flag_cell
`default_nettype wire

// [hw/peripheral_irq_flags.sv]
// peripheral interrupt request flags with an AXI4-Lite slave
// assumes event inputs arrive from outside and are synchronised here
//
// Notes on behaviour
// - flags set regardless of any enable
// - flags stay set until software writes zero
// - fail-safe clock event sets reg1 bit 7
// - out-of-threshold conversion sets reg1 bit 1
// - conversion completion sets reg1 bit 0
// - checksum busy falling sets reg7 bit 6
// - generator two shutdown sets reg7 bit 1
// - generator one shutdown sets reg7 bit 0
// - all flags reset to zero
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flags
  import irq_flags_pkg::*;
(
  input wire logic sys_clk_i, // system clock, 100 MHz
  input wire logic rst_b_i, // synchronous reset, active low
  // event sources, levels from other blocks
  input wire logic osc_failsafe_evt_i, // fail-safe clock detected
  input wire logic clock_switch_evt_i, // clock switch completed
  input wire logic conv_outside_evt_i, // result beyond threshold
  input wire logic conv_done_evt_i, // conversion finished
  input wire logic scanner_done_evt_i, // scanner finished
  input wire logic checksum_busy_i, // checksum engine busy level
  input wire logic memory_op_done_evt_i, // memory operation done
  input wire logic rollover_evt_i, // oscillator rollover
  input wire logic wave3_shutdown_i, // generator three in shutdown
  input wire logic wave2_shutdown_i, // generator two in shutdown
  input wire logic wave1_shutdown_i, // generator one in shutdown
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // interrupt
  output logic irq_o // high while an unmasked event bit is set
);
  localparam int NSRC = 11; // number of event sources

  // raw event vector, order matches the flag map below
  logic [NSRC-1:0] raw_src;
  assign raw_src = {osc_failsafe_evt_i, clock_switch_evt_i,
                    conv_outside_evt_i, conv_done_evt_i,
                    scanner_done_evt_i, checksum_busy_i,
                    memory_op_done_evt_i, rollover_evt_i,
                    wave3_shutdown_i, wave2_shutdown_i,
                    wave1_shutdown_i};

  // two-stage synchroniser and previous-level stage
  logic [NSRC-1:0] sync1_reg; // first stage, read only by second
  logic [NSRC-1:0] sync2_reg; // second stage
  logic [NSRC-1:0] prev_reg; // delayed copy for edge detect
  logic [NSRC-1:0] sync1_next;
  logic [NSRC-1:0] sync2_next;
  logic [NSRC-1:0] prev_next;

  // synchroniser next values
  always_comb
  begin
    sync1_next = raw_src;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
  end

  // synchroniser registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
    end
  end

  // event pulses: rising edge, except checksum which is falling
  logic [NSRC-1:0] rise;
  logic [NSRC-1:0] fall;
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  // set strobes per flag bit
  logic [7:0] set1; // register 1 sets
  logic [7:0] set7; // register 7 sets
  always_comb
  begin
    set1 = 8'h00;
    set7 = 8'h00;
    set1[OSC_FAILSAFE_BIT] = rise[10];
    set1[CLOCK_SWITCH_BIT] = rise[9];
    set1[CONV_THRESH_BIT] = rise[8];
    set1[CONV_DONE_BIT] = rise[7];
    set7[SCANNER_BIT] = rise[6];
    set7[CHECKSUM_BIT] = fall[5]; // busy falling edge
    set7[MEMOP_BIT] = rise[4];
    set7[ROLLOVER_BIT] = rise[3];
    set7[WAVE3_BIT] = rise[2];
    set7[WAVE2_BIT] = rise[1];
    set7[WAVE1_BIT] = rise[0];
  end

  // ---- axi write channel ----
  logic aw_held_reg; // write address captured
  logic w_held_reg; // write data captured
  logic [11:0] awaddr_reg; // captured address
  logic [31:0] wdata_reg; // captured data
  logic [3:0] wstrb_reg; // captured strobes
  logic bvalid_reg; // response pending
  logic [1:0] bresp_reg; // response code
  logic aw_held_next;
  logic w_held_next;
  logic [11:0] awaddr_next;
  logic [31:0] wdata_next;
  logic [3:0] wstrb_next;
  logic bvalid_next;
  logic [1:0] bresp_next;
  logic wr_fire; // both halves present, perform write
  logic wr_hit1; // write to register 1 low byte
  logic wr_hit7; // write to register 7 low byte

  assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_hit1 = wr_fire && (awaddr_reg == FLAGS1_OFFSET) &&
                   wstrb_reg[0];
  assign wr_hit7 = wr_fire && (awaddr_reg == FLAGS7_OFFSET) &&
                   wstrb_reg[0];

  // write channel next state: take address and data in any order
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata_i;
      wstrb_next = s_axi_wstrb_i;
    end
    if (wr_fire)
    begin
      // response once both halves are in
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      case (awaddr_reg)
        FLAGS1_OFFSET, FLAGS7_OFFSET, EVSTAT_OFFSET, EVMASK_OFFSET:
          bresp_next = RESP_OKAY;
        default:
          bresp_next = RESP_SLVERR; // unmapped address
      endcase
    end
    else if (bvalid_reg && s_axi_bready_i)
    begin
      bvalid_next = 1'b0;
    end
  end

  // write channel registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;

  // ---- flag bits, one cell per implemented bit ----
  logic [7:0] flags1; // register 1 contents
  logic [7:0] flags7; // register 7 contents
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_bits
      if (FLAGS1_IMPL[gi])
      begin : g_f1
        // writing zero clears, writing one leaves the flag alone
        flag_cell u_cell1 (
          .sys_clk_i(sys_clk_i),
          .rst_b_i(rst_b_i),
          .set_i(set1[gi]),
          .clr_i(wr_hit1 && !wdata_reg[gi]),
          .flag_o(flags1[gi])
        );
      end
      else
      begin : g_u1
        assign flags1[gi] = 1'b0; // unimplemented reads zero
      end
      if (FLAGS7_IMPL[gi])
      begin : g_f7
        flag_cell u_cell7 (
          .sys_clk_i(sys_clk_i),
          .rst_b_i(rst_b_i),
          .set_i(set7[gi]),
          .clr_i(wr_hit7 && !wdata_reg[gi]),
          .flag_o(flags7[gi])
        );
      end
      else
      begin : g_u7
        assign flags7[gi] = 1'b0; // unimplemented reads zero
      end
    end
  endgenerate

  // ---- sticky event status, mask and interrupt ----
  logic [15:0] evstat_reg; // sticky event bits, read clears
  logic [15:0] evmask_reg; // interrupt mask, one enables
  logic [15:0] evstat_next;
  logic [15:0] evmask_next;
  logic rd_clr_stat; // a read of status is accepted

  // status next: read clears, new events win over the clear
  always_comb
  begin
    evstat_next = evstat_reg;
    evmask_next = evmask_reg;
    if (rd_clr_stat)
    begin
      evstat_next = EVENT_RESET;
    end
    evstat_next = evstat_next | {set7, set1};
    if (wr_fire && (awaddr_reg == EVMASK_OFFSET))
    begin
      if (wstrb_reg[0])
      begin
        evmask_next[7:0] = wdata_reg[7:0] & FLAGS1_IMPL;
      end
      if (wstrb_reg[1])
      begin
        evmask_next[15:8] = wdata_reg[15:8] & FLAGS7_IMPL;
      end
    end
  end

  // status and mask registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      evstat_reg <= EVENT_RESET;
      evmask_reg <= EVENT_RESET;
    end
    else
    begin
      evstat_reg <= evstat_next;
      evmask_reg <= evmask_next;
    end
  end

  assign irq_o = |(evstat_reg & evmask_reg);

  // ---- axi read channel ----
  logic rvalid_reg; // read data pending
  logic [31:0] rdata_reg; // read data
  logic [1:0] rresp_reg; // read response
  logic rvalid_next;
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;
  logic rd_take; // read address accepted

  assign s_axi_arready_o = !rvalid_reg;
  assign rd_take = s_axi_arvalid_i && !rvalid_reg;
  assign rd_clr_stat = rd_take && (s_axi_araddr_i == EVSTAT_OFFSET);

  // read decode, data registered one cycle after address
  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rd_take)
    begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (s_axi_araddr_i)
        FLAGS1_OFFSET: rdata_next = {24'h000000, flags1};
        FLAGS7_OFFSET: rdata_next = {24'h000000, flags7};
        EVSTAT_OFFSET: rdata_next = {16'h0000, evstat_reg};
        EVMASK_OFFSET: rdata_next = {16'h0000, evmask_reg};
        default:
        begin
          rdata_next = 32'h0000_0000; // unmapped
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready_i)
    begin
      rvalid_next = 1'b0;
    end
  end

  // read channel registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end
    else
    begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
endmodule : peripheral_irq_flags
`default_nettype wire

// [testbench/peripheral_irq_flags_asserts.sv]
// bus and interrupt checks for the peripheral flag block
// assumes it is bound to the block top and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flags_checker
  import irq_flags_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic irq_o
);
  // one clock domain, all checks idle in reset
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  AST_RESET_STATE:
    assert property ($rose(rst_b_i) |-> !irq_o && !s_axi_rvalid_o
      && !s_axi_bvalid_o && s_axi_awready_o && s_axi_arready_o)
    else $error("outputs not idle after reset");
  AST_IRQ_HOLDS:
    assert property (irq_o && !s_axi_arvalid_i && !s_axi_awvalid_i
      && !s_axi_wvalid_i && s_axi_awready_o && s_axi_wready_o |=> irq_o)
    else $error("interrupt fell with no software access");
  AST_AW_BLOCKED:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");
  AST_AR_BLOCKED:
    assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while data pending");
  AST_READ_ANSWER:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data late");
  AST_WRITE_ANSWER:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response late");
  AST_UPPER_ZERO:
    assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
    else $error("unused read bits set");
  AST_ERROR_DATA:
    assert property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR
      |-> ($rose(s_axi_rvalid_o) || $stable(s_axi_rdata_o))
      && s_axi_rdata_o == 32'h0)
    else $error("error read returned data");
endmodule : peripheral_irq_flags_checker
bind peripheral_irq_flags peripheral_irq_flags_checker u_checker
(
  .sys_clk_i, .rst_b_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .irq_o
);
`default_nettype wire

// [testbench/tb_peripheral_irq_flags.sv]
// self-checking bench for the peripheral flag block
// assumes the bound checker is compiled with the design
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_irq_flags;
  import irq_flags_pkg::*;
  logic clk = 1'b0; // system clock
  logic rst_b = 1'b0; // reset, active low
  logic [15:0] ev = 16'h0000; // sources in flag bit order
  logic [15:0] acc; // expected flags
  logic [15:0] impl = {FLAGS7_IMPL, FLAGS1_IMPL}; // live bits
  logic [11:0] ad = 12'h000; // address for both channels
  logic [31:0] wd = 32'h0; // write data
  logic [3:0] ws = 4'h0; // strobes
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  wire awr, wr, bv, arr, rv, irq; // block outputs
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [31:0] rd; // last read data
  logic [1:0] rp; // last response
  int bad_count = 0;
  int checks = 0;
  peripheral_irq_flags dut
  (
    .sys_clk_i(clk), .rst_b_i(rst_b), .osc_failsafe_evt_i(ev[7]),
    .clock_switch_evt_i(ev[6]), .conv_outside_evt_i(ev[1]),
    .conv_done_evt_i(ev[0]), .scanner_done_evt_i(ev[15]),
    .checksum_busy_i(ev[14]), .memory_op_done_evt_i(ev[13]),
    .rollover_evt_i(ev[12]), .wave3_shutdown_i(ev[10]),
    .wave2_shutdown_i(ev[9]), .wave1_shutdown_i(ev[8]),
    .s_axi_awaddr_i(ad), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bry), .s_axi_araddr_i(ad), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .irq_o(irq)
  );
  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // compare, count, report a mismatch
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    begin
      checks++;
      if (got !== exp)
      begin
        bad_count++;
        $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask : chk
  // counts, verdict, end of run
  task automatic results();
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask : results
  // one axi4-lite transfer, a write when w is set
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    int n;
    begin
      n = 0;
      @(posedge clk);
      ad <= a;
      wd <= d;
      ws <= s;
      awv <= w;
      wv <= w;
      bry <= w;
      arv <= !w;
      rry <= !w;
      do
      begin
        @(posedge clk);
        if (awv && awr) awv <= 1'b0;
        if (wv && wr) wv <= 1'b0;
        if (arv && arr) arv <= 1'b0;
        n++;
      end while (!(w ? bv : rv) && n < 100);
      rd = rdata;
      rp = w ? bresp : rresp;
      bry <= 1'b0;
      rry <= 1'b0;
      bad_count += (n >= 100);
      if (n >= 100) results();
    end
  endtask : bus
  // read a register and compare its data
  task automatic rchk(input string nm, input logic [11:0] a,
    input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0, 4'h0);
      chk(nm, rd, e);
    end
  endtask : rchk
  // both flag registers against the expected state
  task automatic rflags();
    begin
      rchk("flags1", FLAGS1_OFFSET, {24'h0, acc[7:0]});
      rchk("flags7", FLAGS7_OFFSET, {24'h0, acc[15:8]});
    end
  endtask : rflags
  // pulse one source: level rises, busy line falls
  task automatic evt(input int k);
    begin
      @(posedge clk);
      ev[k] <= 1'b1;
      repeat (2) @(posedge clk);
      ev[k] <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask : evt
  // test sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 16; i += 4)
    begin
      rchk("reset value", 12'(i), 32'h0);
    end
    $display("test reset done");
    acc = 16'h0000;
    for (int k = 0; k < 16; k++)
    begin
      if (impl[k])
      begin
        evt(k);
        acc[k] = 1'b1;
        rflags();
      end
    end
    chk("masked irq", irq, 32'h0);
    rchk("status", EVSTAT_OFFSET, {16'h0, acc});
    rchk("status", EVSTAT_OFFSET, 32'h0);
    rflags();
    $display("test events done");
    // ones keep a flag, zeros clear it, strobe off ignored
    bus(1'b1, FLAGS1_OFFSET, 32'hFF, 4'hF);
    rflags();
    bus(1'b1, FLAGS1_OFFSET, 32'h41, 4'hF);
    acc[7:0] = 8'h41;
    rflags();
    bus(1'b1, FLAGS1_OFFSET, 32'h0, 4'h0);
    rflags();
    bus(1'b1, FLAGS1_OFFSET, 32'h0, 4'hF);
    bus(1'b1, FLAGS7_OFFSET, 32'h2, 4'hF);
    acc = 16'h0200;
    rflags();
    $display("test clears done");
    // masked and unmasked events on the interrupt line
    bus(1'b1, EVMASK_OFFSET, 32'hFFFF, 4'hF);
    rchk("mask", EVMASK_OFFSET, 32'hF7C3);
    bus(1'b1, EVMASK_OFFSET, 32'h1, 4'hF);
    evt(8);
    chk("irq", irq, 32'h0);
    evt(0);
    chk("irq", irq, 32'h1);
    rchk("status", EVSTAT_OFFSET, 32'h101);
    chk("irq", irq, 32'h0);
    $display("test interrupt done");
    // unmapped place and read-only status
    bus(1'b1, 12'h010, 32'hFFFF, 4'hF);
    chk("bresp", rp, RESP_SLVERR);
    rchk("unmapped", 12'h010, 32'h0);
    chk("rresp", rp, RESP_SLVERR);
    bus(1'b1, EVSTAT_OFFSET, 32'hFFFF, 4'hF);
    chk("bresp", rp, RESP_OKAY);
    $display("test access done");
    // reset in mid-run clears flags and mask
    evt(7);
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    acc = 16'h0000;
    rflags();
    rchk("mask", EVMASK_OFFSET, 32'h0);
    $display("test midreset done");
    results();
  end
endmodule : tb_peripheral_irq_flags
`default_nettype wire
